// File: core/modbus_temp_consts.vh
// constants for the temperature register map slave
`ifndef MODBUS_TEMP_CONSTS_VH
`define MODBUS_TEMP_CONSTS_VH
// Overview of operation
// - Each reading is offered both as a 32-bit IEEE754 float and as a scaled 16-bit signed integer.
// - Measurement registers are read-only and answer function 0x03 and 0x04 in exactly the same way.
// - Float readings take two registers each: Celsius at 0x3EA, Fahrenheit at 0x3EC, Kelvin at 0x3F0.
// - Integer readings take one register each: Celsius at 0xFA1, Fahrenheit at 0xFA2, Kelvin at 0xFA4.
// - Integer Celsius is temperature times 100, integer Fahrenheit and Kelvin are temperature times 50.
// - Wire addresses count from zero, so a wire address is the register number minus one.
// - A float puts its low 16 bits in the lower register and its upper 16 bits in the next, each sent high byte first.
// - A read request holds address, function, start, count and CRC; its reply holds address, function, byte count, data, CRC.
// - Only frames sent to the configured slave address, 233 after reset, are answered.
// - Slave address and protocol settings are written at 0x00 and 0x01 with function 0x06.

`define FN_READ_HOLD    8'h03
`define FN_READ_INPUT   8'h04
`define FN_WRITE_SINGLE 8'h06
`define EXC_FLAG        8'h80
`define EXC_BAD_FUNC    8'h01
`define EXC_BAD_ADDR    8'h02
`define EXC_BAD_VALUE   8'h03

`define ADDR_C_FLOAT    16'h03EA
`define ADDR_F_FLOAT    16'h03EC
`define ADDR_K_FLOAT    16'h03F0
`define ADDR_C_INT      16'h0FA1
`define ADDR_F_INT      16'h0FA2
`define ADDR_K_INT      16'h0FA4
`define ADDR_SLAVE_ID   16'h0000
`define ADDR_PROTO      16'h0001

`define SLAVE_ADDR_RST  8'hE9
`define SLAVE_ADDR_MIN  16'h0001
`define SLAVE_ADDR_MAX  16'h00F7
`define PROTO_RST       16'h0000
`define MAX_QTY         16'h007D
`define REQ_LEN         4'h8
`define WR_RESP_LEN     8'h08
`define EXC_RESP_LEN    8'h05
`define RD_RESP_BASE    8'h05

`define W_C_LO          4'h0
`define W_C_HI          4'h1
`define W_F_LO          4'h2
`define W_F_HI          4'h3
`define W_K_LO          4'h4
`define W_K_HI          4'h5
`define W_C_INT         4'h6
`define W_F_INT         4'h7
`define W_K_INT         4'h8
`define W_NONE          4'hF
`define SNAP_WORDS      9

`define F_MUL           20'sh00009
`define F_DIV           20'sh0000A
`define F_OFFSET        20'sh00640
`define K_OFFSET        20'sh06AB3

`define CRC_INIT        16'hFFFF
`define CRC_POLY        16'hA001
`define CLK_MHZ         200
`define GAP_US          4000
`define GAP_CYCLES_DEF  20'hC3500
`endif

// File: core/snapshot_mem.v
// captured register image with registered read port
`timescale 1ns/100ps
`include "modbus_temp_consts.vh"
module snapshot_mem (
    input  wire                        clk_i,
    input  wire                        rst_n_i,
    input  wire                        capture_i,
    input  wire [`SNAP_WORDS*16-1:0]   image_i,
    input  wire [3:0]                  rd_idx_i,
    output reg  [15:0]                 rd_word_o
);

    reg [`SNAP_WORDS*16-1:0] store_r;

    genvar g;
    generate
        for (g = 0; g < `SNAP_WORDS; g = g + 1) begin : gen_word
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    store_r[g*16 +: 16] <= 16'h0000;
                end else if (capture_i) begin
                    store_r[g*16 +: 16] <= image_i[g*16 +: 16];
                end
            end
        end
    endgenerate

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_word_o <= 16'h0000;
        end else if (rd_idx_i < `SNAP_WORDS) begin
            rd_word_o <= store_r[rd_idx_i*16 +: 16];
        end else begin
            rd_word_o <= 16'h0000;
        end
    end

endmodule

// File: core/modbus_temp_regmap.v
// rtu slave: request decode, temperature register map, reply build
`timescale 1ns/100ps
`include "modbus_temp_consts.vh"
module modbus_temp_regmap #(
    parameter [19:0] GAP_CYCLES = `GAP_CYCLES_DEF
) (
    input  wire        core_clk_i,
    input  wire        nrst_i,
    input  wire [7:0]  rx_data_i,
    input  wire        rx_valid_i,
    input  wire        tx_ready_i,
    input  wire        meas_valid_i,
    input  wire [31:0] meas_c_float_i,
    input  wire [31:0] meas_f_float_i,
    input  wire [31:0] meas_k_float_i,
    input  wire [15:0] meas_c_x100_i,
    output reg  [7:0]  tx_data_o,
    output reg         tx_valid_o,
    output reg         drive_en_o,
    output reg  [7:0]  slave_addr_o,
    output reg  [15:0] proto_cfg_o
);

    localparam [1:0] ST_RX   = 2'h0;
    localparam [1:0] ST_PREP = 2'h1;
    localparam [1:0] ST_LOAD = 2'h2;
    localparam [1:0] ST_SEND = 2'h3;

    localparam [1:0] RESP_READ  = 2'h0;
    localparam [1:0] RESP_WRITE = 2'h1;
    localparam [1:0] RESP_EXC   = 2'h2;

    function [15:0] crc_step;
        input [15:0] crc;
        input [7:0]  data;
        integer      i;
        reg [15:0]   c;
        begin
            c = crc ^ {8'h00, data};
            for (i = 0; i < 8; i = i + 1) begin
                if (c[0]) begin
                    c = (c >> 1) ^ `CRC_POLY;
                end else begin
                    c = c >> 1;
                end
            end
            crc_step = c;
        end
    endfunction

    // wire address to snapshot word, float low half at lower address
    function [3:0] map_idx;
        input [15:0] addr;
        begin
            case (addr)
                `ADDR_C_FLOAT:          map_idx = `W_C_LO;
                `ADDR_C_FLOAT + 16'h1:  map_idx = `W_C_HI;
                `ADDR_F_FLOAT:          map_idx = `W_F_LO;
                `ADDR_F_FLOAT + 16'h1:  map_idx = `W_F_HI;
                `ADDR_K_FLOAT:          map_idx = `W_K_LO;
                `ADDR_K_FLOAT + 16'h1:  map_idx = `W_K_HI;
                `ADDR_C_INT:            map_idx = `W_C_INT;
                `ADDR_F_INT:            map_idx = `W_F_INT;
                `ADDR_K_INT:            map_idx = `W_K_INT;
                default:                map_idx = `W_NONE;
            endcase
        end
    endfunction

    // whole span must lie inside one mapped block
    function range_ok;
        input [15:0] start;
        input [15:0] qty;
        reg   [16:0] last;
        begin
            last = {1'b0, start} + {1'b0, qty} - 17'h00001;
            range_ok = (start >= `ADDR_C_FLOAT && last <= {1'b0, `ADDR_F_FLOAT + 16'h1}) ||
                       (start >= `ADDR_K_FLOAT && last <= {1'b0, `ADDR_K_FLOAT + 16'h1}) ||
                       (start >= `ADDR_C_INT && last <= {1'b0, `ADDR_F_INT}) ||
                       (start == `ADDR_K_INT && last == {1'b0, `ADDR_K_INT});
        end
    endfunction

    reg         rst_s1_r;
    reg         rst_s2_r;
    wire        rst_n;

    reg [1:0]   state_r;
    reg [3:0]   rx_cnt_r;
    reg [63:0]  rx_buf_r;
    reg [15:0]  crc_rx_r;
    reg [19:0]  gap_cnt_r;
    reg [1:0]   resp_kind_r;
    reg [7:0]   resp_func_r;
    reg [7:0]   exc_code_r;
    reg [7:0]   tx_len_r;
    reg [7:0]   tx_pos_r;
    reg [15:0]  crc_tx_r;

    reg [31:0]  live_c_float_r;
    reg [31:0]  live_f_float_r;
    reg [31:0]  live_k_float_r;
    reg [15:0]  live_c_int_r;
    reg [15:0]  live_f_int_r;
    reg [15:0]  live_k_int_r;

    reg [1:0]   kind_nxt;
    reg [7:0]   exc_nxt;
    reg [7:0]   len_nxt;
    reg         wr_slave_nxt;
    reg         wr_proto_nxt;
    reg [7:0]   tx_byte;
    reg [7:0]   data_pos;

    wire [15:0] rd_word;
    wire [7:0]  req_slave = rx_buf_r[7:0];
    wire [7:0]  req_func  = rx_buf_r[15:8];
    wire [15:0] req_start = {rx_buf_r[23:16], rx_buf_r[31:24]};
    wire [15:0] req_val   = {rx_buf_r[39:32], rx_buf_r[47:40]};
    wire        frame_end = (rx_cnt_r != 4'h0) && !rx_valid_i && (gap_cnt_r == GAP_CYCLES - 20'h00001);
    wire        frame_good = (rx_cnt_r == `REQ_LEN) && (crc_rx_r == 16'h0000) &&
                             (req_slave == slave_addr_o);
    wire        accept = (state_r == ST_RX) && frame_end && frame_good;
    wire        is_read = (req_func == `FN_READ_HOLD) || (req_func == `FN_READ_INPUT);
    wire [15:0] rd_addr = req_start + {9'h000, data_pos[7:1]};

    // scaled integers: F*50 = C100*0.9+1600, K*50 = (C100+27315)/2
    wire signed [19:0] c_ext = {{4{meas_c_x100_i[15]}}, meas_c_x100_i};
    wire signed [19:0] f_x50 = (c_ext * `F_MUL) / `F_DIV + `F_OFFSET;
    wire signed [19:0] k_x50 = (c_ext + `K_OFFSET) >>> 1;

    assign rst_n = rst_s2_r;

    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            live_c_float_r <= 32'h00000000;
            live_f_float_r <= 32'h00000000;
            live_k_float_r <= 32'h00000000;
            live_c_int_r   <= 16'h0000;
            live_f_int_r   <= 16'h0000;
            live_k_int_r   <= 16'h0000;
        end else if (meas_valid_i) begin
            live_c_float_r <= meas_c_float_i;
            live_f_float_r <= meas_f_float_i;
            live_k_float_r <= meas_k_float_i;
            live_c_int_r   <= meas_c_x100_i;
            live_f_int_r   <= f_x50[15:0];
            live_k_int_r   <= k_x50[15:0];
        end
    end

    snapshot_mem u_snapshot (
        .clk_i     (core_clk_i),
        .rst_n_i   (rst_n),
        .capture_i (accept && is_read),
        .image_i   ({live_k_int_r, live_f_int_r, live_c_int_r,
                     live_k_float_r, live_f_float_r, live_c_float_r}),
        .rd_idx_i  (map_idx(rd_addr)),
        .rd_word_o (rd_word)
    );

    // request decode and reply selection
    always @* begin
        kind_nxt     = RESP_EXC;
        exc_nxt      = `EXC_BAD_FUNC;
        len_nxt      = `EXC_RESP_LEN;
        wr_slave_nxt = 1'b0;
        wr_proto_nxt = 1'b0;
        if (is_read) begin
            if (req_val == 16'h0000 || req_val > `MAX_QTY) begin
                exc_nxt = `EXC_BAD_VALUE;
            end else if (!range_ok(req_start, req_val)) begin
                exc_nxt = `EXC_BAD_ADDR;
            end else begin
                kind_nxt = RESP_READ;
                len_nxt  = {req_val[6:0], 1'b0} + `RD_RESP_BASE;
            end
        end else if (req_func == `FN_WRITE_SINGLE) begin
            if (req_start == `ADDR_SLAVE_ID) begin
                if (req_val < `SLAVE_ADDR_MIN || req_val > `SLAVE_ADDR_MAX) begin
                    exc_nxt = `EXC_BAD_VALUE;
                end else begin
                    kind_nxt     = RESP_WRITE;
                    len_nxt      = `WR_RESP_LEN;
                    wr_slave_nxt = 1'b1;
                end
            end else if (req_start == `ADDR_PROTO) begin
                kind_nxt     = RESP_WRITE;
                len_nxt      = `WR_RESP_LEN;
                wr_proto_nxt = 1'b1;
            end else begin
                exc_nxt = `EXC_BAD_ADDR;
            end
        end
    end

    // reply byte for the current position
    always @* begin
        data_pos = tx_pos_r - 8'h03;
        tx_byte  = exc_code_r;
        if (tx_pos_r == tx_len_r - 8'h02) begin
            tx_byte = crc_tx_r[7:0];
        end else if (tx_pos_r == tx_len_r - 8'h01) begin
            tx_byte = crc_tx_r[15:8];
        end else if (tx_pos_r == 8'h00) begin
            tx_byte = slave_addr_o;
        end else if (tx_pos_r == 8'h01) begin
            tx_byte = resp_func_r;
        end else begin
            case (resp_kind_r)
                RESP_READ: begin
                    if (tx_pos_r == 8'h02) begin
                        tx_byte = {req_val[6:0], 1'b0};
                    end else if (data_pos[0]) begin
                        tx_byte = rd_word[7:0];
                    end else begin
                        tx_byte = rd_word[15:8];
                    end
                end
                RESP_WRITE: begin
                    tx_byte = rx_buf_r[{tx_pos_r[2:0], 3'b000} +: 8];
                end
                default: begin
                    tx_byte = exc_code_r;
                end
            endcase
        end
    end

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r      <= ST_RX;
            rx_cnt_r     <= 4'h0;
            rx_buf_r     <= 64'h0000000000000000;
            crc_rx_r     <= `CRC_INIT;
            gap_cnt_r    <= 20'h00000;
            resp_kind_r  <= RESP_EXC;
            resp_func_r  <= 8'h00;
            exc_code_r   <= 8'h00;
            tx_len_r     <= `EXC_RESP_LEN;
            tx_pos_r     <= 8'h00;
            crc_tx_r     <= `CRC_INIT;
            tx_data_o    <= 8'h00;
            tx_valid_o   <= 1'b0;
            drive_en_o   <= 1'b0;
            slave_addr_o <= `SLAVE_ADDR_RST;
            proto_cfg_o  <= `PROTO_RST;
        end else begin
            case (state_r)
                ST_RX: begin
                    if (rx_valid_i) begin
                        gap_cnt_r <= 20'h00000;
                        if (rx_cnt_r < `REQ_LEN) begin
                            rx_buf_r[{rx_cnt_r[2:0], 3'b000} +: 8] <= rx_data_i;
                            crc_rx_r <= crc_step(crc_rx_r, rx_data_i);
                        end
                        if (rx_cnt_r != 4'hF) begin
                            rx_cnt_r <= rx_cnt_r + 4'h1;
                        end
                    end else if (frame_end) begin
                        rx_cnt_r  <= 4'h0;
                        crc_rx_r  <= `CRC_INIT;
                        gap_cnt_r <= 20'h00000;
                        if (frame_good) begin
                            resp_kind_r <= kind_nxt;
                            exc_code_r  <= exc_nxt;
                            tx_len_r    <= len_nxt;
                            resp_func_r <= (kind_nxt == RESP_EXC) ? (req_func | `EXC_FLAG) : req_func;
                            tx_pos_r    <= 8'h00;
                            crc_tx_r    <= `CRC_INIT;
                            drive_en_o  <= 1'b1;
                            state_r     <= ST_PREP;
                            if (wr_slave_nxt) begin
                                slave_addr_o <= req_val[7:0];
                            end
                            if (wr_proto_nxt) begin
                                proto_cfg_o <= req_val;
                            end
                        end
                    end else if (rx_cnt_r != 4'h0) begin
                        gap_cnt_r <= gap_cnt_r + 20'h00001;
                    end
                end
                ST_PREP: begin
                    state_r <= ST_LOAD;
                end
                ST_LOAD: begin
                    tx_data_o  <= tx_byte;
                    tx_valid_o <= 1'b1;
                    if (tx_pos_r < tx_len_r - 8'h02) begin
                        crc_tx_r <= crc_step(crc_tx_r, tx_byte);
                    end
                    state_r <= ST_SEND;
                end
                ST_SEND: begin
                    if (tx_ready_i) begin
                        tx_valid_o <= 1'b0;
                        if (tx_pos_r == tx_len_r - 8'h01) begin
                            drive_en_o <= 1'b0;
                            tx_pos_r   <= 8'h00;
                            state_r    <= ST_RX;
                        end else begin
                            tx_pos_r <= tx_pos_r + 8'h01;
                            state_r  <= ST_PREP;
                        end
                    end
                end
                default: begin
                    state_r <= ST_RX;
                end
            endcase
        end
    end

endmodule

// File: tb/modbus_temp_regmap_sva.sv
// checker for the reply timing and stored settings of the register map slave
`timescale 1ns/100ps
module modbus_temp_regmap_sva #(
    parameter [19:0] GAP_CYCLES = 20'h00014
) (
    input wire logic        core_clk_i,
    input wire logic        nrst_i,
    input wire logic        rx_valid_i,
    input wire logic        tx_ready_i,
    input wire logic [7:0]  tx_data_o,
    input wire logic        tx_valid_o,
    input wire logic        drive_en_o,
    input wire logic [7:0]  slave_addr_o,
    input wire logic [15:0] proto_cfg_o
);
    logic [19:0] idle_cnt_r;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    // edges since the last received byte, saturating
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            idle_cnt_r <= 20'h00000;
        else if (rx_valid_i)
            idle_cnt_r <= 20'h00000;
        else if (idle_cnt_r != 20'hFFFFF)
            idle_cnt_r <= idle_cnt_r + 20'h00001;
    end

    sequence s_accept;
        $rose(drive_en_o);
    endsequence
    sequence s_first_byte;
        !tx_valid_o ##1 (tx_valid_o && tx_data_o == slave_addr_o);
    endsequence
    sequence s_taken;
        tx_valid_o && tx_ready_i;
    endsequence

    a_reply_start: assert property (s_accept |=> s_first_byte)
        else $error("reply did not open with the slave address two cycles after accept");
    a_tx_in_reply: assert property (tx_valid_o |-> drive_en_o)
        else $error("reply byte offered with the driver off");
    a_tx_hold_stall: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("reply byte changed or dropped while stalled");
    a_taken_drop: assert property (s_taken |=> !tx_valid_o)
        else $error("valid stayed high after a byte was taken");
    a_next_byte: assert property (s_taken ##1 drive_en_o |=> !tx_valid_o ##1 tx_valid_o)
        else $error("next reply byte not offered on time");
    a_drive_end: assert property ($fell(drive_en_o) |-> $past(tx_valid_o) && $past(tx_ready_i))
        else $error("driver released without a final byte taken");
    a_frame_gap: assert property (s_accept |-> idle_cnt_r >= GAP_CYCLES)
        else $error("frame accepted before the silent gap ran out");
    a_addr_write: assert property (!$stable(slave_addr_o) |-> $rose(drive_en_o))
        else $error("slave address changed outside a frame accept");
    a_proto_write: assert property (!$stable(proto_cfg_o) |-> $rose(drive_en_o))
        else $error("protocol word changed outside a frame accept");
    a_addr_range: assert property (slave_addr_o != 8'h00 && slave_addr_o <= 8'hF7)
        else $error("slave address outside 1 to 247");
endmodule

bind modbus_temp_regmap modbus_temp_regmap_sva #(.GAP_CYCLES(GAP_CYCLES)) u_modbus_temp_regmap_sva (
    .core_clk_i, .nrst_i, .rx_valid_i, .tx_ready_i, .tx_data_o, .tx_valid_o, .drive_en_o, .slave_addr_o,
    .proto_cfg_o);

// File: tb/modbus_master_model.sv
// rtu master model: frames requests onto the byte link and takes reply bytes
`timescale 1ns/100ps
module modbus_master_model (
    input  wire logic       clk_i,
    output logic      [7:0] rx_data_o,
    output logic            rx_valid_o,
    output logic            tx_ready_o
);
    bit slow = 1'b0;

    initial begin
        rx_data_o = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b0;
    end

    // slow mode stalls reply bytes at random
    always @(negedge clk_i) begin
        tx_ready_o <= slow ? ($urandom_range(2, 0) == 0) : 1'b1;
    end

    // whole eight-byte request frame in one call; bytes spaced well inside the frame gap
    task automatic send_frame(input logic [63:0] fr);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk_i);
            rx_data_o = fr[i*8 +: 8];
            rx_valid_o = 1'b1;
            @(negedge clk_i);
            rx_valid_o = 1'b0;
            rx_data_o = ~fr[i*8 +: 8];
            repeat (2) @(negedge clk_i);
        end
    endtask
endmodule

// File: tb/tb_modbus_temp_regmap.sv
// self-checking bench: request and reply traffic against the register map slave
`timescale 1ns/100ps
`include "modbus_temp_consts.vh"
module tb_modbus_temp_regmap;
    localparam logic [19:0] GAP = 20'h00014;
    logic        core_clk_i, nrst_i, meas_valid_i, rx_valid_i, tx_ready_i, tx_valid_o, drive_en_o;
    logic [7:0]  rx_data_i, tx_data_o, slave_addr_o, cur_slave;
    logic [15:0] meas_c_x100_i, proto_cfg_o, exp_proto;
    logic [31:0] meas_c_float_i, meas_f_float_i, meas_k_float_i;
    logic [39:0] tbl[$];
    logic [7:0]  exp_q[$];
    int          errors = 0;
    int          checked = 0;

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    modbus_temp_regmap #(.GAP_CYCLES(GAP)) u_modbus_temp_regmap (.core_clk_i, .nrst_i, .rx_data_i, .rx_valid_i,
        .tx_ready_i, .meas_valid_i, .meas_c_float_i, .meas_f_float_i, .meas_k_float_i, .meas_c_x100_i,
        .tx_data_o, .tx_valid_o, .drive_en_o, .slave_addr_o, .proto_cfg_o);
    modbus_master_model u_modbus_master_model (.clk_i(core_clk_i), .rx_data_o(rx_data_i),
        .rx_valid_o(rx_valid_i), .tx_ready_o(tx_ready_i));

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // each byte taken is matched against the oldest expected byte
    always @(posedge core_clk_i) begin
        if (nrst_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
            if (exp_q.size() == 0)
                cmp({8'h00, tx_data_o}, 16'hFFFF);
            else
                cmp({8'h00, tx_data_o}, {8'h00, exp_q.pop_front()});
        end
    end

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = `CRC_INIT;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // bit 16 marks a mapped word
    function automatic logic [16:0] word_at(input logic [15:0] a);
        int c;
        int f;
        int k;
        c = $signed(meas_c_x100_i);
        f = c * 9 / 10 + 1600;
        k = (c + 27315) >>> 1;
        case (a)
            16'h03EA: return {1'b1, meas_c_float_i[15:0]};
            16'h03EB: return {1'b1, meas_c_float_i[31:16]};
            16'h03EC: return {1'b1, meas_f_float_i[15:0]};
            16'h03ED: return {1'b1, meas_f_float_i[31:16]};
            16'h03F0: return {1'b1, meas_k_float_i[15:0]};
            16'h03F1: return {1'b1, meas_k_float_i[31:16]};
            16'h0FA1: return {1'b1, meas_c_x100_i};
            16'h0FA2: return {1'b1, f[15:0]};
            16'h0FA4: return {1'b1, k[15:0]};
            default: return 17'h00000;
        endcase
    endfunction

    task automatic set_meas();
        @(negedge core_clk_i);
        meas_c_float_i = $urandom();
        meas_f_float_i = $urandom();
        meas_k_float_i = $urandom();
        meas_c_x100_i = 16'($urandom_range(17500, 0)) - 16'h1B58;
        meas_valid_i = 1'b1;
        @(negedge core_clk_i);
        meas_valid_i = 1'b0;
    endtask

    task automatic req(input logic [7:0] a, fn, input logic [15:0] st, v, input bit bad, mid);
        logic [7:0]  b[$];
        logic [7:0]  r[$];
        logic [15:0] c;
        logic [15:0] rc;
        logic [16:0] w;
        logic [7:0]  ex;
        b = '{a, fn, st[15:8], st[7:0], v[15:8], v[7:0]};
        c = crc16(b) ^ {15'h0000, bad};
        ex = 8'h00;
        if (fn == `FN_READ_HOLD || fn == `FN_READ_INPUT) begin
            if (v == 16'h0000 || v > `MAX_QTY)
                ex = `EXC_BAD_VALUE;
            r = '{a, fn, 8'(v * 2)};
            for (int i = 0; i < v && ex == 8'h00; i++) begin
                w = word_at(st + 16'(i));
                if (!w[16])
                    ex = `EXC_BAD_ADDR;
                r.push_back(w[15:8]);
                r.push_back(w[7:0]);
            end
        end else if (fn == `FN_WRITE_SINGLE) begin
            if (st > 16'h0001)
                ex = `EXC_BAD_ADDR;
            else if (st == 16'h0000 && (v == 16'h0000 || v > 16'h00F7))
                ex = `EXC_BAD_VALUE;
            r = b;
            if (st == 16'h0000)
                r[0] = v[7:0];
        end else
            ex = `EXC_BAD_FUNC;
        if (ex != 8'h00)
            r = '{a, fn | `EXC_FLAG, ex};
        if (!bad && a == cur_slave) begin
            if (fn == `FN_WRITE_SINGLE && ex == 8'h00 && st == 16'h0000)
                cur_slave = v[7:0];
            if (fn == `FN_WRITE_SINGLE && ex == 8'h00 && st == 16'h0001)
                exp_proto = v;
            rc = crc16(r);
            r.push_back(rc[7:0]);
            r.push_back(rc[15:8]);
            foreach (r[i]) exp_q.push_back(r[i]);
        end
        u_modbus_master_model.send_frame({a, fn, st, v, c[7:0], c[15:8]});
        if (mid) begin
            for (int i = 0; i < 200 && drive_en_o !== 1'b1; i++) @(negedge core_clk_i);
            set_meas();
        end
        repeat (GAP + 8) @(negedge core_clk_i);
        for (int i = 0; i < 4000 && (exp_q.size() != 0 || drive_en_o !== 1'b0); i++) @(negedge core_clk_i);
        cmp(16'(exp_q.size()), 16'h0000);
        cmp({15'h0000, drive_en_o}, 16'h0000);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h3157));
        nrst_i = 1'b0;
        meas_valid_i = 1'b0;
        {meas_c_float_i, meas_f_float_i, meas_k_float_i, meas_c_x100_i} = '0;
        cur_slave = `SLAVE_ADDR_RST;
        exp_proto = `PROTO_RST;
        tbl = '{40'h03_03EA_0002, 40'h03_03EC_0002, 40'h03_03F0_0002, 40'h03_0FA1_0002, 40'h03_0FA4_0001,
                40'h03_03EA_0004, 40'h03_03E9_0002, 40'h03_03EE_0001, 40'h03_03EF_0002, 40'h03_0FA2_0002,
                40'h03_0FA4_0002, 40'h03_0000_0001, 40'h03_03EA_0000, 40'h03_03EA_007E, 40'h05_03EA_0002,
                40'h06_03EA_0001};
        repeat (16) @(negedge core_clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        cmp({8'h00, slave_addr_o}, 16'h00E9);
        cmp(proto_cfg_o, `PROTO_RST);
        set_meas();
        for (int p = 0; p < 2; p++) begin
            u_modbus_master_model.slow = p[0];
            foreach (tbl[i]) begin
                req(cur_slave, (p == 1 && tbl[i][39:32] == 8'h03) ? 8'h04 : tbl[i][39:32], tbl[i][31:16],
                    tbl[i][15:0], 1'b0, 1'b0);
            end
            set_meas();
        end
        repeat (10) begin
            req(cur_slave, 8'($urandom_range(4, 3)), 16'($urandom_range(16'h03F2, 16'h03E8)),
                16'($urandom_range(3, 1)), 1'b0, 1'b0);
        end
        req(8'h11, 8'h03, 16'h03EA, 16'h0002, 1'b0, 1'b0);
        req(8'h00, 8'h03, 16'h03EA, 16'h0002, 1'b0, 1'b0);
        req(cur_slave, 8'h03, 16'h03EA, 16'h0002, 1'b1, 1'b0);
        req(cur_slave, 8'h03, 16'h03EA, 16'h0004, 1'b0, 1'b1);
        req(cur_slave, 8'h06, 16'h0001, 16'($urandom()), 1'b0, 1'b0);
        cmp(proto_cfg_o, exp_proto);
        req(cur_slave, 8'h06, 16'h0000, 16'h00F8, 1'b0, 1'b0);
        req(cur_slave, 8'h06, 16'h0000, 16'h00F7, 1'b0, 1'b0);
        cmp({8'h00, slave_addr_o}, 16'h00F7);
        req(8'hE9, 8'h03, 16'h03EA, 16'h0002, 1'b0, 1'b0);
        req(cur_slave, 8'h04, 16'h0FA1, 16'h0002, 1'b0, 1'b0);
        req(cur_slave, 8'h06, 16'h0000, 16'h00E9, 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule
